// >>> hwo_offset_cal_regs.sv
/*
 * Register bank for waveform time offsets and closed-loop drive parameters, with an APB slave,
 * portion classification of library samples, portion length adjustment and drive level capping.
 * Assumes synchronous inputs on sys_clk, a 32-bit APB master and a calibration engine that
 * pulses cal_done once per finished calibration.
 */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Negative samples other than overdrive and braking are negative sustain.
// - Negative sustain length offset by signed register times interval.
// - Braking is the most negative sample.
// - Brake offset only applies in open loop.
// - Brake length offset by signed register times interval.
// - Nominal level is closed-loop full-scale reference.
// - Calibration reads nominal level, host writes first.
// - Auto overdrive and brake capped at limit in closed loop only.
// - Calibration stores loss compensation, resets to 13.
// - Loss compensation derived from measured impedance.
// - Feedback gain derived from seed register.
module hwo_offset_cal_regs #(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned LEN_W = 16
) (
   input wire logic sys_clk,                     // System clock, 250 MHz
   input wire logic srst,                        // Synchronous reset, active high
   input wire logic psel,                        // APB select
   input wire logic penable,                     // APB enable
   input wire logic pwrite,                      // APB write direction
   input wire logic [ADDR_W-1:0] paddr,          // APB byte address
   input wire logic [31:0] pwdata,               // APB write data
   output logic [31:0] prdata,                   // APB read data
   output logic pready,                          // APB ready
   output logic pslverr,                         // APB error for unmapped address
   input wire logic scan_valid,                  // Waveform sample presented for extreme scan
   input wire logic scan_first,                  // First sample of a new waveform scan
   input wire logic signed [7:0] scan_sample,    // Sample being scanned
   input wire logic seg_valid,                   // Portion to be adjusted is presented
   input wire logic signed [7:0] seg_sample,     // Sample value of the portion
   input wire logic [LEN_W-1:0] seg_len,         // Nominal portion length in ms
   output logic seg_valid_out,                   // Adjusted portion valid, one-cycle pulse
   output hwo_pkg::hwo_portion_t seg_portion,    // Portion class of the adjusted portion
   output logic [LEN_W-1:0] seg_len_out,         // Adjusted portion length in ms
   input wire logic drive_auto,                  // Automatic overdrive or braking in progress
   input wire logic [7:0] drive_req,             // Requested drive magnitude
   output logic [7:0] drive_level,               // Capped drive magnitude
   input wire logic cal_done,                    // Calibration finished, one-cycle pulse
   input wire logic [7:0] cal_impedance,         // Measured actuator impedance
   input wire logic [7:0] cal_seed_result,       // Feedback gain seed found by calibration
   output logic [7:0] cal_nominal_level,         // Nominal level given to calibration
   output logic [7:0] fb_gain_seed,              // Seed for closed-loop feedback gain
   output logic [7:0] loss_comp,                 // Resistive loss compensation
   output logic closed_loop                      // Closed-loop mode selected
);
   import hwo_pkg::*;

   // -------------------------------------------------------------
   // Parameter checks
   // -------------------------------------------------------------
   // The register indices need six address bits above the byte lane.
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
      $error("hwo_offset_cal_regs: ADDR_W must be 8 to 32");
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [7:0] neg_sustain_offset_reg;
   logic [7:0] brake_time_offset_reg;
   logic [7:0] nominal_reg;
   logic [7:0] od_limit_reg;
   logic [7:0] loss_comp_reg;
   logic [7:0] fb_seed_reg;
   logic closed_loop_reg;
   logic [7:0] interval_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic signed [7:0] wave_min_reg;
   logic signed [7:0] wave_max_reg;
   logic extrema_valid_reg;
   hwo_portion_t last_portion_reg;
   logic seg_valid_out_reg;
   hwo_portion_t seg_portion_reg;
   logic [LEN_W-1:0] seg_len_out_reg;
   logic [7:0] drive_level_reg;

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   wire logic setup_phase;
   wire logic wr_en;
   wire logic aligned;
   wire logic [ADDR_W-3:0] word_idx;
   wire logic hit_neg;
   wire logic hit_brake;
   wire logic hit_nom;
   wire logic hit_od;
   wire logic hit_loss;
   wire logic hit_seed;
   wire logic hit_ctrl;
   wire logic hit_interval;
   wire logic hit_status;
   wire logic hit_any;
   wire logic [7:0] status_val;
   wire logic [7:0] rdata_byte;
   wire logic [7:0] wbyte;

   assign setup_phase = psel && !penable && !pready_reg;
   assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign aligned = (paddr[1:0] == 2'b00);
   assign word_idx = paddr[ADDR_W-1:2];
   assign hit_neg = aligned && (word_idx == (ADDR_W-2)'(IDX_NEG_SUSTAIN));
   assign hit_brake = aligned && (word_idx == (ADDR_W-2)'(IDX_BRAKE_TIME));
   assign hit_nom = aligned && (word_idx == (ADDR_W-2)'(IDX_NOMINAL));
   assign hit_od = aligned && (word_idx == (ADDR_W-2)'(IDX_OD_LIMIT));
   assign hit_loss = aligned && (word_idx == (ADDR_W-2)'(IDX_LOSS_COMP));
   assign hit_seed = aligned && (word_idx == (ADDR_W-2)'(IDX_FB_SEED));
   assign hit_ctrl = aligned && (word_idx == (ADDR_W-2)'(IDX_CTRL));
   assign hit_interval = aligned && (word_idx == (ADDR_W-2)'(IDX_INTERVAL));
   assign hit_status = aligned && (word_idx == (ADDR_W-2)'(IDX_STATUS));
   assign hit_any = hit_neg | hit_brake | hit_nom | hit_od | hit_loss | hit_seed |
                    hit_ctrl | hit_interval | hit_status;
   assign wbyte = pwdata[7:0];

   assign status_val = {5'h00, extrema_valid_reg, last_portion_reg};

   assign rdata_byte = hit_neg ? neg_sustain_offset_reg :
                       hit_brake ? brake_time_offset_reg :
                       hit_nom ? nominal_reg :
                       hit_od ? od_limit_reg :
                       hit_loss ? loss_comp_reg :
                       hit_seed ? fb_seed_reg :
                       hit_ctrl ? {7'h00, closed_loop_reg} :
                       hit_interval ? interval_reg :
                       hit_status ? status_val : 8'h00;

   // -------------------------------------------------------------
   // APB answer
   // -------------------------------------------------------------
   // Ready comes one cycle after setup, so every transfer has a fixed single-cycle access phase.
   // Read data holds the value loaded at the last setup, read or write; only the access cycle gives it meaning.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= setup_phase;
         pslverr_reg <= setup_phase && !hit_any;
         if (setup_phase) begin
            prdata_reg <= {24'h000000, rdata_byte};
         end
      end
   end

   // -------------------------------------------------------------
   // Calibration results
   // -------------------------------------------------------------
   // Compensation scales with impedance times the nominal level the routine was given.
   wire logic [15:0] loss_product;
   wire logic [15:0] loss_scaled;
   wire logic [7:0] loss_derived;

   assign loss_product = cal_impedance * nominal_reg;
   assign loss_scaled = loss_product >> LOSS_COMP_SHIFT;
   assign loss_derived = (loss_scaled > 16'h00FF) ? 8'hFF : loss_scaled[7:0];

   // -------------------------------------------------------------
   // Write strobes
   // -------------------------------------------------------------
   // The status word has no strobe: a write to it is answered without error and dropped.
   wire logic wr_neg;
   wire logic wr_brake;
   wire logic wr_nom;
   wire logic wr_od;
   wire logic wr_loss;
   wire logic wr_seed;
   wire logic wr_ctrl;
   wire logic wr_interval;
   wire logic ld_loss;
   wire logic ld_seed;
   wire logic [7:0] loss_comp_next;
   wire logic [7:0] fb_seed_next;

   assign wr_neg = wr_en && hit_neg;
   assign wr_brake = wr_en && hit_brake;
   assign wr_nom = wr_en && hit_nom;
   assign wr_od = wr_en && hit_od;
   assign wr_loss = wr_en && hit_loss;
   assign wr_seed = wr_en && hit_seed;
   assign wr_ctrl = wr_en && hit_ctrl;
   assign wr_interval = wr_en && hit_interval;

   // A calibration result landing with a software write to the same register wins,
   // so a finished calibration is never lost.
   assign ld_loss = cal_done || wr_loss;
   assign ld_seed = cal_done || wr_seed;
   assign loss_comp_next = cal_done ? loss_derived : wbyte;
   assign fb_seed_next = cal_done ? cal_seed_result : wbyte;

   // -------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         neg_sustain_offset_reg <= RST_NEG_SUSTAIN;
         brake_time_offset_reg <= RST_BRAKE_TIME;
         nominal_reg <= RST_NOMINAL;
         od_limit_reg <= RST_OD_LIMIT;
         loss_comp_reg <= RST_LOSS_COMP;
         fb_seed_reg <= RST_FB_SEED;
         closed_loop_reg <= 1'b0;
         interval_reg <= RST_INTERVAL;
      end else begin
         if (wr_neg) begin
            neg_sustain_offset_reg <= wbyte;
         end
         if (wr_brake) begin
            brake_time_offset_reg <= wbyte;
         end
         if (wr_nom) begin
            nominal_reg <= wbyte;
         end
         if (wr_od) begin
            od_limit_reg <= wbyte;
         end
         if (ld_loss) begin
            loss_comp_reg <= loss_comp_next;
         end
         if (ld_seed) begin
            fb_seed_reg <= fb_seed_next;
         end
         if (wr_ctrl) begin
            closed_loop_reg <= wbyte[CTRL_CLOSED_LOOP_BIT];
         end
         if (wr_interval) begin
            interval_reg <= wbyte;
         end
      end
   end

   // -------------------------------------------------------------
   // Waveform extremes
   // -------------------------------------------------------------
   // The extremes are gathered in a scan ahead of playback; a scan restarted with scan_first
   // discards the previous waveform's values.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wave_min_reg <= 8'sh00;
         wave_max_reg <= 8'sh00;
         extrema_valid_reg <= 1'b0;
      end else if (scan_valid) begin
         extrema_valid_reg <= 1'b1;
         if (scan_first || (scan_sample < wave_min_reg)) begin
            wave_min_reg <= scan_sample;
         end
         if (scan_first || (scan_sample > wave_max_reg)) begin
            wave_max_reg <= scan_sample;
         end
      end
   end

   // -------------------------------------------------------------
   // Portion classification and length adjustment
   // -------------------------------------------------------------
   hwo_portion_t cur_portion;
   wire logic [7:0] seg_offset;
   wire logic [LEN_W-1:0] adj_len;

   hwo_portion_classify u_classify (
      .sample(seg_sample),
      .wave_min(wave_min_reg),
      .wave_max(wave_max_reg),
      .portion(cur_portion)
   );

   // Closed loop brakes on its own, so the brake offset is dropped there.
   assign seg_offset = (cur_portion == HWO_PORTION_NEG_SUSTAIN) ? neg_sustain_offset_reg :
                       ((cur_portion == HWO_PORTION_BRAKE) && !closed_loop_reg) ?
                       brake_time_offset_reg : 8'h00;

   hwo_duration_adjust #(
      .LEN_W(LEN_W)
   ) u_adjust (
      .len_in(seg_len),
      .offset(seg_offset),
      .interval(interval_reg),
      .len_out(adj_len)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seg_valid_out_reg <= 1'b0;
         seg_portion_reg <= HWO_PORTION_OTHER;
         seg_len_out_reg <= '0;
         last_portion_reg <= HWO_PORTION_OTHER;
      end else begin
         seg_valid_out_reg <= seg_valid;
         if (seg_valid) begin
            seg_portion_reg <= cur_portion;
            seg_len_out_reg <= adj_len;
            last_portion_reg <= cur_portion;
         end
      end
   end

   // -------------------------------------------------------------
   // Drive level capping
   // -------------------------------------------------------------
   // In closed loop the nominal level is full scale, except during automatic overdrive and
   // braking where the higher peak limit applies. Open loop passes the request unchanged.
   wire logic [7:0] drive_cap;
   wire logic [7:0] drive_next;

   assign drive_cap = drive_auto ? od_limit_reg : nominal_reg;
   assign drive_next = (closed_loop_reg && (drive_req > drive_cap)) ? drive_cap : drive_req;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         drive_level_reg <= 8'h00;
      end else begin
         drive_level_reg <= drive_next;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign seg_valid_out = seg_valid_out_reg;
   assign seg_portion = seg_portion_reg;
   assign seg_len_out = seg_len_out_reg;
   assign drive_level = drive_level_reg;
   assign cal_nominal_level = nominal_reg;
   assign fb_gain_seed = fb_seed_reg;
   assign loss_comp = loss_comp_reg;
   assign closed_loop = closed_loop_reg;

endmodule : hwo_offset_cal_regs
`default_nettype wire

// >>> hwo_pkg.sv
/*
 * Shared constants and types of the haptic waveform offset and calibration register bank.
 * Assumes a 32-bit APB with word-aligned registers; the byte address of a register is four times its index.
 */
package hwo_pkg;

   // -------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [5:0] IDX_NEG_SUSTAIN = 6'h1C;
   localparam logic [5:0] IDX_BRAKE_TIME = 6'h1D;
   localparam logic [5:0] IDX_NOMINAL = 6'h1F;
   localparam logic [5:0] IDX_OD_LIMIT = 6'h20;
   localparam logic [5:0] IDX_LOSS_COMP = 6'h21;
   localparam logic [5:0] IDX_FB_SEED = 6'h22;
   localparam logic [5:0] IDX_CTRL = 6'h30;
   localparam logic [5:0] IDX_INTERVAL = 6'h31;
   localparam logic [5:0] IDX_STATUS = 6'h32;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_NEG_SUSTAIN = 8'h00;
   localparam logic [7:0] RST_BRAKE_TIME = 8'h00;
   localparam logic [7:0] RST_NOMINAL = 8'h3F;
   localparam logic [7:0] RST_OD_LIMIT = 8'h89;
   localparam logic [7:0] RST_LOSS_COMP = 8'h0D;
   localparam logic [7:0] RST_FB_SEED = 8'h6D;
   localparam logic [7:0] RST_INTERVAL = 8'h05;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int unsigned CTRL_CLOSED_LOOP_BIT = 0;
   localparam int unsigned STAT_EXTREMA_BIT = 2;
   localparam int unsigned LOSS_COMP_SHIFT = 7;

   // -------------------------------------------------------------
   // Waveform portions
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      HWO_PORTION_OTHER,
      HWO_PORTION_OVERDRIVE,
      HWO_PORTION_NEG_SUSTAIN,
      HWO_PORTION_BRAKE
   } hwo_portion_t;

endpackage : hwo_pkg

// >>> hwo_portion_classify.sv
/*
 * Sorts one library waveform sample into its portion from the waveform's extreme values.
 * Assumes the extremes were gathered over the same waveform before playback.
 */
`timescale 1ns/10ps
`default_nettype none
module hwo_portion_classify (
   input wire logic signed [7:0] sample,         // Drive sample being played
   input wire logic signed [7:0] wave_min,       // Most negative sample of the waveform
   input wire logic signed [7:0] wave_max,       // Most positive sample of the waveform
   output hwo_pkg::hwo_portion_t portion         // Portion the sample belongs to
);
   import hwo_pkg::*;

   wire logic is_od;
   wire logic is_brake;
   wire logic is_neg;

   assign is_od = (sample == wave_max) && (wave_max > 8'sh00);
   assign is_brake = (sample == wave_min) && (wave_min < 8'sh00);
   assign is_neg = (sample < 8'sh00) && !is_od;

   assign portion = is_od ? HWO_PORTION_OVERDRIVE :
                    is_brake ? HWO_PORTION_BRAKE :
                    is_neg ? HWO_PORTION_NEG_SUSTAIN : HWO_PORTION_OTHER;

endmodule : hwo_portion_classify
`default_nettype wire

// >>> hwo_duration_adjust.sv
/*
 * Adds a signed sample-interval offset to the nominal length of a waveform portion.
 * Assumes lengths and the interval share one unit of milliseconds.
 */
`timescale 1ns/10ps
`default_nettype none
module hwo_duration_adjust #(
   parameter int unsigned LEN_W = 16
) (
   input wire logic [LEN_W-1:0] len_in,          // Nominal portion length
   input wire logic signed [7:0] offset,         // Signed offset in intervals
   input wire logic [7:0] interval,              // Sample period setting
   output logic [LEN_W-1:0] len_out              // Adjusted portion length
);
   import hwo_pkg::*;

   wire logic signed [16:0] delta;
   wire logic signed [LEN_W+17:0] sum;
   wire logic signed [LEN_W+17:0] len_max;

   if (LEN_W < 8 || LEN_W > 30) begin : g_len_w_check
      $error("hwo_duration_adjust: LEN_W out of range");
   end

   assign delta = offset * $signed({1'b0, interval});
   assign sum = $signed({18'h00000, len_in}) + (LEN_W+18)'(delta);
   assign len_max = $signed({18'h00000, {LEN_W{1'b1}}});

   // A long negative offset empties the portion instead of wrapping round.
   assign len_out = (sum < 0) ? '0 :
                    (sum > len_max) ? {LEN_W{1'b1}} : sum[LEN_W-1:0];

endmodule : hwo_duration_adjust
`default_nettype wire

// >>> hwo_assertions.sv
/*
 * Concurrent checks on the ports of the waveform offset and calibration register bank.
 * Assumes one clock domain and a synchronous active-high reset; attached by bind from the testbench.
 */
`timescale 1ns/10ps
`default_nettype none
module hwo_assertions (
   input wire logic sys_clk,                // Clock
   input wire logic srst,                   // Reset
   input wire logic psel,                   // APB select
   input wire logic penable,                // APB enable
   input wire logic pwrite,                 // APB direction
   input wire logic [31:0] prdata,          // APB read data
   input wire logic pready,                 // APB ready
   input wire logic pslverr,                // APB error
   input wire logic seg_valid,              // Portion presented
   input wire logic seg_valid_out,          // Portion answered
   input wire logic drive_auto,             // Automatic drive phase
   input wire logic [7:0] drive_req,        // Requested drive
   input wire logic [7:0] drive_level,      // Capped drive
   input wire logic cal_done,               // Calibration finished
   input wire logic [7:0] cal_seed_result,  // Seed from calibration
   input wire logic [7:0] cal_nominal_level, // Nominal level
   input wire logic [7:0] fb_gain_seed,     // Feedback seed
   input wire logic closed_loop             // Mode
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("prdata upper bits set");
   a_seg_answer: assert property (seg_valid |=> seg_valid_out)
      else $error("no segment answer");
   // An attempt begun on a reset edge would meet reset values one cycle on, so none begins there.
   a_open_drive_pass: assert property (!srst && !closed_loop |=> drive_level == $past(drive_req))
      else $error("open loop drive altered");
   a_closed_nominal_cap: assert property (!srst && closed_loop && !drive_auto |=> drive_level ==
      (($past(drive_req) < $past(cal_nominal_level)) ? $past(drive_req) : $past(cal_nominal_level)))
      else $error("closed loop drive not capped at nominal");
   a_seed_capture: assert property (!srst && cal_done |=> fb_gain_seed == $past(cal_seed_result))
      else $error("seed not captured");
   a_seed_hold: assert property (!srst && !cal_done && !(psel && penable && pwrite) |=> $stable(fb_gain_seed))
      else $error("seed changed without cause");
   a_mode_hold: assert property (!srst && !(psel && penable && pwrite) |=> $stable(closed_loop))
      else $error("mode changed without write");
endmodule : hwo_assertions
`default_nettype wire

// >>> tb_haptic_waveform_offset_cal_regs.sv
/*
 * Self-checking testbench of the waveform offset and calibration register bank.
 * Assumes the design package is compiled first and the checker module is available for bind.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_haptic_waveform_offset_cal_regs;
   import hwo_pkg::*;
   logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, scan_sample = 8'h00, seg_sample = 8'h00, drive_req = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, seg_valid_out, closed_loop, er;
   logic scan_valid = 1'b0, scan_first = 1'b0, seg_valid = 1'b0, drive_auto = 1'b0, cal_done = 1'b0;
   logic [15:0] seg_len = 16'h0000, seg_len_out;
   logic [7:0] cal_impedance = 8'h00, cal_seed_result = 8'h00, drive_level, cal_nominal_level;
   logic [7:0] fb_gain_seed, loss_comp;
   hwo_portion_t seg_portion;
   int mismatches = 0, samples_checked = 0;
   logic [7:0] ra [8] = '{8'h70, 8'h74, 8'h7C, 8'h80, 8'h84, 8'h88, 8'hC0, 8'hC4};
   logic [7:0] rr [8] = '{8'h00, 8'h00, 8'h3F, 8'h89, 8'h0D, 8'h6D, 8'h00, 8'h05};
   logic [7:0] rw [8] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'h96, 8'h69, 8'h01, 8'h02};
   logic [7:0] sc [4] = '{8'h32, 8'hB0, 8'hEC, 8'h0A};

   hwo_offset_cal_regs i_hwo_offset_cal_regs (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .scan_valid, .scan_first, .scan_sample, .seg_valid, .seg_sample, .seg_len,
      .seg_valid_out, .seg_portion, .seg_len_out, .drive_auto, .drive_req, .drive_level, .cal_done,
      .cal_impedance, .cal_seed_result, .cal_nominal_level, .fb_gain_seed, .loss_comp, .closed_loop);

   always #2 sys_clk = ~sys_clk;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // The request stands until the rising edge that samples pready high; data and error are
   // taken at that edge and the request is released right after it.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   task automatic seg(input logic [7:0] s, input logic [15:0] len, input logic [1:0] p, input logic [15:0] el);
      @(posedge sys_clk);
      seg_valid <= 1'b1;
      seg_sample <= s;
      seg_len <= len;
      @(posedge sys_clk);
      seg_valid <= 1'b0;
      @(negedge sys_clk);
      chk(seg_valid_out, 32'h1);
      chk(seg_portion, p);
      chk(seg_len_out, el);
   endtask : seg

   task automatic drv(input logic a, input logic [7:0] r, input logic [7:0] e);
      @(posedge sys_clk);
      drive_auto <= a;
      drive_req <= r;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(drive_level, e);
   endtask : drv

   task automatic cal(input logic [7:0] imp, input logic [7:0] s, input logic [7:0] e);
      @(posedge sys_clk);
      cal_done <= 1'b1;
      cal_impedance <= imp;
      cal_seed_result <= s;
      @(posedge sys_clk);
      cal_done <= 1'b0;
      @(negedge sys_clk);
      chk(loss_comp, e);
      chk(fb_gain_seed, s);
   endtask : cal

   task automatic complete_run;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (3000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rdc(ra[i], {24'h000000, rr[i]});
         apb(1'b1, ra[i], {24'hFFFFFF, rw[i]});
         rdc(ra[i], {24'h000000, rw[i]});
      end
      apb(1'b0, 8'h78, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h71, 32'hFF);
      chk(er, 32'h1);
      rdc(8'h70, 32'hA5);
      apb(1'b1, 8'h70, 32'hFE);
      apb(1'b1, 8'h74, 32'h03);
      apb(1'b1, 8'hC4, 32'h04);
      apb(1'b1, 8'hC0, 32'h00);
      foreach (sc[i]) begin
         @(posedge sys_clk);
         scan_valid <= 1'b1;
         scan_first <= (i == 0);
         scan_sample <= sc[i];
      end
      @(posedge sys_clk);
      scan_valid <= 1'b0;
      seg(8'hEC, 16'h0064, HWO_PORTION_NEG_SUSTAIN, 16'h005C);
      seg(8'hB0, 16'h0064, HWO_PORTION_BRAKE, 16'h0070);
      seg(8'h32, 16'h0064, HWO_PORTION_OVERDRIVE, 16'h0064);
      seg(8'h0A, 16'h0064, HWO_PORTION_OTHER, 16'h0064);
      seg(8'hEC, 16'h0005, HWO_PORTION_NEG_SUSTAIN, 16'h0000);
      apb(1'b1, 8'hC0, 32'h01);
      seg(8'hB0, 16'h0064, HWO_PORTION_BRAKE, 16'h0064);
      rdc(8'hC8, 32'h07);
      apb(1'b1, 8'h7C, 32'h40);
      apb(1'b1, 8'h80, 32'h60);
      drv(1'b0, 8'h50, 8'h40);
      drv(1'b1, 8'h50, 8'h50);
      drv(1'b1, 8'h70, 8'h60);
      chk(cal_nominal_level, 32'h40);
      cal(8'h80, 8'h44, 8'h40);
      rdc(8'h84, 32'h40);
      rdc(8'h88, 32'h44);
      apb(1'b1, 8'h7C, 32'hFF);
      cal(8'hFF, 8'h12, 8'hFF);
      apb(1'b1, 8'hC0, 32'h00);
      drv(1'b1, 8'hF0, 8'hF0);
      // A reset in mid-run must bring the calibration results back to their power-on values.
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      chk({loss_comp, fb_gain_seed, cal_nominal_level, 7'h00, closed_loop}, 32'h0D6D3F00);
      rdc(8'h74, 32'h0);
      complete_run();
   end
endmodule : tb_haptic_waveform_offset_cal_regs

bind hwo_offset_cal_regs hwo_assertions i_hwo_assertions (.sys_clk, .srst, .psel, .penable, .pwrite, .prdata,
   .pready, .pslverr, .seg_valid, .seg_valid_out, .drive_auto, .drive_req, .drive_level, .cal_done,
   .cal_seed_result, .cal_nominal_level, .fb_gain_seed, .closed_loop);
`default_nettype wire
